// File: include/aesba_pkg.sv
// aesba_pkg: constants, carrier structs and state types of the byte-wide
// aes-128 accelerator.
// assumes one 100 mhz clock shared with the processor bus and dma logic.
package aesba_pkg;

  // operating modes, two-bit field
  localparam logic [1:0] MODE_ENCRYPT    = 2'h0;
  localparam logic [1:0] MODE_KEY_DERIVE = 2'h1;
  localparam logic [1:0] MODE_DECRYPT    = 2'h2;
  localparam logic [1:0] MODE_DERIVE_DEC = 2'h3;

  // last byte indices of the input and output phases, one below the byte counts
  localparam logic [4:0] IN_BYTES_LONG  = 5'h1f;
  localparam logic [4:0] IN_BYTES_SHORT = 5'h0f;
  localparam logic [3:0] OUT_BYTES_LAST = 4'hf;

  // computation phase length in clock cycles, per mode
  localparam logic [10:0] CYC_ENCRYPT    = 11'd892;
  localparam logic [10:0] CYC_KEY_DERIVE = 11'd320;
  localparam logic [10:0] CYC_DECRYPT    = 11'd892;
  localparam logic [10:0] CYC_DERIVE_DEC = 11'd1228;

  // round engine step counts
  localparam logic [4:0] ROUNDS      = 5'h0a;
  localparam logic [4:0] ROUNDS_TWICE = 5'h14;

  // reset values
  localparam logic [127:0] BLOCK_RESET = 128'h0;
  localparam logic [7:0]   BYTE_RESET  = 8'h00;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_INPUT,
    PH_COMPUTE,
    PH_OUTPUT
  } aesba_phase_t;

  // control bits driven by software
  typedef struct packed {
    logic       enable;
    logic [1:0] mode;
    logic       dma_request_enable;
    logic       compute_done_irq_enable;
    logic       error_irq_enable;
    logic       compute_done_clear;
    logic       error_flags_clear;
  } aesba_ctrl_t;

  // status flags seen by software
  typedef struct packed {
    logic write_error_flag;
    logic read_error_flag;
    logic compute_done_flag;
  } aesba_status_t;

  // whole state of the core
  typedef struct packed {
    aesba_phase_t  phase;
    logic [127:0]  key;
    logic [127:0]  data;
    logic [4:0]    in_cnt;
    logic [3:0]    out_cnt;
    logic [10:0]   cyc;
    logic [4:0]    step;
    logic [7:0]    dout;
    aesba_status_t status;
    logic          irq;
    logic          dma_in;
    logic          dma_out;
  } aesba_state_t;

endpackage : aesba_pkg

// File: hdl/aesba_core.sv
// aesba_core: byte-wide aes-128 accelerator with input, compute and output
// phases, error flags, interrupt line and two dma request lines.
// assumes control and strobes come from logic on CORE_CLK; a read strobe
// samples OUTPUT_BYTE_REG in the same cycle.
//
// Function
// - aes-128 block cipher plus decryption key derivation
// - mode field selects one of four operations
// - enable starts input phase, 32 or 16 bytes
// - last byte starts timed computation phase
// - computation end sets done flag, interrupt
// - sixteen result bytes read out msb first
// - any idle time between byte accesses
// - early output read sets read error flag
// - late input write sets write error flag
// - error flags raise interrupt when enabled
// - errors never stop ongoing processing
// - done flag cleared by its clear bit
// - disable reinitialises, enable restarts input phase
// - dma input request per needed byte
// - dma output request per available byte
// - dma mode loops back to input phase
// - error clear bit clears both error flags
module aesba_core (
  // clock and reset
  input  wire logic                    CORE_CLK,
  input  wire logic                    RESET_N,
  // control bits
  input  wire aesba_pkg::aesba_ctrl_t  CTRL,
  // byte data path
  input  wire logic                    INPUT_BYTE_WRITE,
  input  wire logic [7:0]              INPUT_BYTE_REG,
  input  wire logic                    OUTPUT_BYTE_READ,
  output logic [7:0]                   OUTPUT_BYTE_REG,
  // status, interrupt and dma requests
  output aesba_pkg::aesba_status_t     STATUS,
  output logic                         IRQ,
  output logic                         DMA_IN_REQ,
  output logic                         DMA_OUT_REQ
);

  aesba_pkg::aesba_state_t s_q;
  aesba_pkg::aesba_state_t s_d;

  // gf(2^8) doubling
  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
  endfunction : xt

  // gf(2^8) product
  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [7:0] r;
    logic [7:0] x;
    r = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) r = r ^ x;
      x = xt(x);
    end
    return r;
  endfunction : gmul

  // multiplicative inverse as a^254, zero maps to zero
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] sq;
    r  = 8'h01;
    sq = a;
    for (int i = 1; i < 8; i++) begin
      sq = gmul(sq, sq);
      r  = gmul(r, sq);
    end
    return r;
  endfunction : ginv

  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] b;
    b = ginv(a);
    return b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]}
           ^ {b[3:0], b[7:4]} ^ 8'h63;
  endfunction : sbox

  function automatic logic [7:0] isbox(input logic [7:0] a);
    logic [7:0] b;
    b = {a[6:0], a[7]} ^ {a[4:0], a[7:5]} ^ {a[1:0], a[7:2]} ^ 8'h05;
    return ginv(b);
  endfunction : isbox

  // round constant of round r, 1 to 10
  function automatic logic [7:0] rcon(input logic [4:0] r);
    logic [7:0] v;
    v = 8'h01;
    for (int i = 1; i < 10; i++) begin
      if (5'(i) < r) v = xt(v);
    end
    return v;
  endfunction : rcon

  function automatic logic [31:0] sub_rot(input logic [31:0] w);
    return {sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
  endfunction : sub_rot

  // next round key
  function automatic logic [127:0] key_fwd(input logic [127:0] k,
                                           input logic [4:0]   r);
    logic [31:0] n0;
    logic [31:0] n1;
    logic [31:0] n2;
    logic [31:0] n3;
    n0 = k[127:96] ^ sub_rot(k[31:0]) ^ {rcon(r), 24'h000000};
    n1 = k[95:64] ^ n0;
    n2 = k[63:32] ^ n1;
    n3 = k[31:0] ^ n2;
    return {n0, n1, n2, n3};
  endfunction : key_fwd

  // previous round key from round key r
  function automatic logic [127:0] key_back(input logic [127:0] k,
                                            input logic [4:0]   r);
    logic [31:0] p0;
    logic [31:0] p1;
    logic [31:0] p2;
    logic [31:0] p3;
    p3 = k[31:0] ^ k[63:32];
    p2 = k[63:32] ^ k[95:64];
    p1 = k[95:64] ^ k[127:96];
    p0 = k[127:96] ^ sub_rot(p3) ^ {rcon(r), 24'h000000};
    return {p0, p1, p2, p3};
  endfunction : key_back

  // substitution and row shift, forward or inverse
  function automatic logic [127:0] sub_shift(input logic [127:0] s,
                                             input logic         inv);
    logic [127:0] o;
    int           src;
    o = 128'h0;
    for (int i = 0; i < 16; i++) begin
      src = (i % 4) + 4 * (((i / 4) + (i % 4)) % 4);
      if (inv)
        o[127 - 8 * src -: 8] = isbox(s[127 - 8 * i -: 8]);
      else
        o[127 - 8 * i -: 8] = sbox(s[127 - 8 * src -: 8]);
    end
    return o;
  endfunction : sub_shift

  // column mixing, forward or inverse
  function automatic logic [127:0] mix(input logic [127:0] s,
                                       input logic         inv);
    logic [127:0] o;
    logic [31:0]  cf;
    logic [7:0]   acc;
    o  = 128'h0;
    cf = inv ? 32'h0e0b0d09 : 32'h02030101;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        acc = 8'h00;
        for (int j = 0; j < 4; j++) begin
          acc = acc ^ gmul(s[127 - 8 * (4 * c + j) -: 8],
                           cf[31 - 8 * ((j - r + 4) % 4) -: 8]);
        end
        o[127 - 8 * (4 * c + r) -: 8] = acc;
      end
    end
    return o;
  endfunction : mix

  logic [127:0] nk;
  logic [127:0] nd;
  logic [127:0] res;
  logic [4:0]   st;
  logic [4:0]   rr;
  logic [4:0]   in_last;
  logic [10:0]  target;

  always_comb begin
    s_d = s_q;
    nk  = s_q.key;
    nd  = s_q.data;
    res = s_q.data;
    st  = s_q.step + 5'h01;
    rr  = 5'h00;
    in_last = (CTRL.mode == aesba_pkg::MODE_KEY_DERIVE)
              ? aesba_pkg::IN_BYTES_SHORT : aesba_pkg::IN_BYTES_LONG;
    case (CTRL.mode)
      aesba_pkg::MODE_ENCRYPT:    target = aesba_pkg::CYC_ENCRYPT;
      aesba_pkg::MODE_KEY_DERIVE: target = aesba_pkg::CYC_KEY_DERIVE;
      aesba_pkg::MODE_DECRYPT:    target = aesba_pkg::CYC_DECRYPT;
      default:                    target = aesba_pkg::CYC_DERIVE_DEC;
    endcase
    if (CTRL.compute_done_clear) s_d.status.compute_done_flag = 1'b0;
    if (CTRL.error_flags_clear) begin
      s_d.status.read_error_flag  = 1'b0;
      s_d.status.write_error_flag = 1'b0;
    end
    if (!CTRL.enable) begin
      s_d.phase   = aesba_pkg::PH_IDLE;
      s_d.in_cnt  = 5'h00;
      s_d.out_cnt = 4'h0;
      s_d.cyc     = 11'h000;
      s_d.step    = 5'h00;
    end else begin
      case (s_q.phase)
        aesba_pkg::PH_IDLE: begin
          s_d.phase = aesba_pkg::PH_INPUT;
        end
        aesba_pkg::PH_INPUT: begin
          if (OUTPUT_BYTE_READ) s_d.status.read_error_flag = 1'b1;
          // one byte per write, any spacing
          if (INPUT_BYTE_WRITE) begin
            // even bytes key, odd bytes data; every byte goes to key in key derive mode
            if (CTRL.mode == aesba_pkg::MODE_KEY_DERIVE || !s_q.in_cnt[0])
              nk = {s_q.key[119:0], INPUT_BYTE_REG};
            else
              nd = {s_q.data[119:0], INPUT_BYTE_REG};
            s_d.key    = nk;
            s_d.data   = nd;
            s_d.in_cnt = s_q.in_cnt + 5'h01;
            if (s_q.in_cnt == in_last) begin
              s_d.phase  = aesba_pkg::PH_COMPUTE;
              s_d.in_cnt = 5'h00;
              s_d.cyc    = 11'h000;
              s_d.step   = 5'h00;
              if (CTRL.mode == aesba_pkg::MODE_ENCRYPT ||
                  CTRL.mode == aesba_pkg::MODE_DECRYPT)
                s_d.data = nd ^ nk;
            end
          end
        end
        aesba_pkg::PH_COMPUTE: begin
          if (OUTPUT_BYTE_READ) s_d.status.read_error_flag = 1'b1;
          if (INPUT_BYTE_WRITE) s_d.status.write_error_flag = 1'b1;
          if (s_q.step < ((CTRL.mode == aesba_pkg::MODE_DERIVE_DEC)
                          ? aesba_pkg::ROUNDS_TWICE : aesba_pkg::ROUNDS)) begin
            s_d.step = st;
            if (CTRL.mode == aesba_pkg::MODE_ENCRYPT) begin
              nk = key_fwd(s_q.key, st);
              nd = sub_shift(s_q.data, 1'b0);
              if (st != aesba_pkg::ROUNDS) nd = mix(nd, 1'b0);
              nd = nd ^ nk;
            end else if (CTRL.mode == aesba_pkg::MODE_KEY_DERIVE ||
                         s_q.step < aesba_pkg::ROUNDS &&
                         CTRL.mode == aesba_pkg::MODE_DERIVE_DEC) begin
              nk = key_fwd(s_q.key, st);
              if (st == aesba_pkg::ROUNDS &&
                  CTRL.mode == aesba_pkg::MODE_DERIVE_DEC)
                nd = s_q.data ^ nk;
            end else begin
              rr = (CTRL.mode == aesba_pkg::MODE_DECRYPT)
                   ? aesba_pkg::ROUNDS - s_q.step
                   : aesba_pkg::ROUNDS_TWICE - s_q.step;
              nk = key_back(s_q.key, rr);
              nd = sub_shift(s_q.data, 1'b1) ^ nk;
              if (rr != 5'h01) nd = mix(nd, 1'b1);
            end
            s_d.key  = nk;
            s_d.data = nd;
          end
          s_d.cyc = s_q.cyc + 11'h001;
          if (s_d.cyc == target) begin
            res = (CTRL.mode == aesba_pkg::MODE_KEY_DERIVE) ? nk : nd;
            s_d.data    = res;
            s_d.dout    = res[127:120];
            s_d.out_cnt = 4'h0;
            s_d.phase   = aesba_pkg::PH_OUTPUT;
            s_d.status.compute_done_flag = 1'b1;
          end
        end
        aesba_pkg::PH_OUTPUT: begin
          if (INPUT_BYTE_WRITE) s_d.status.write_error_flag = 1'b1;
          if (OUTPUT_BYTE_READ) begin
            s_d.data    = {s_q.data[119:0], aesba_pkg::BYTE_RESET};
            s_d.dout    = s_q.data[119:112];
            s_d.out_cnt = s_q.out_cnt + 4'h1;
            // back to a new input phase
            if (s_q.out_cnt == aesba_pkg::OUT_BYTES_LAST) begin
              s_d.phase   = aesba_pkg::PH_INPUT;
              s_d.out_cnt = 4'h0;
              s_d.in_cnt  = 5'h00;
            end
          end
        end
        default: begin
          s_d.phase = aesba_pkg::PH_IDLE;
        end
      endcase
    end
    // interrupt from done and error flags
    s_d.irq = (s_d.status.compute_done_flag & CTRL.compute_done_irq_enable)
            | ((s_d.status.read_error_flag | s_d.status.write_error_flag)
               & CTRL.error_irq_enable);
    // input request, dropped for one cycle per write
    s_d.dma_in = CTRL.dma_request_enable
               & (s_d.phase == aesba_pkg::PH_INPUT) & !INPUT_BYTE_WRITE;
    // output request, dropped for one cycle per read
    s_d.dma_out = CTRL.dma_request_enable
                & (s_d.phase == aesba_pkg::PH_OUTPUT) & !OUTPUT_BYTE_READ;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q.phase   <= aesba_pkg::PH_IDLE;
      s_q.key     <= aesba_pkg::BLOCK_RESET;
      s_q.data    <= aesba_pkg::BLOCK_RESET;
      s_q.in_cnt  <= 5'h00;
      s_q.out_cnt <= 4'h0;
      s_q.cyc     <= 11'h000;
      s_q.step    <= 5'h00;
      s_q.dout    <= aesba_pkg::BYTE_RESET;
      s_q.status  <= 3'h0;
      s_q.irq     <= 1'b0;
      s_q.dma_in  <= 1'b0;
      s_q.dma_out <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign OUTPUT_BYTE_REG = s_q.dout;
  assign STATUS          = s_q.status;
  assign IRQ             = s_q.irq;
  assign DMA_IN_REQ      = s_q.dma_in;
  assign DMA_OUT_REQ     = s_q.dma_out;

endmodule : aesba_core

// File: verification/aesba_core_props.sv
// aesba_core_props: port-level timing and flag checks of the accelerator.
// assumes one clock domain and one-cycle strobes from the bench.
module aesba_core_props (
  // clock and reset
  input wire logic                     CORE_CLK,
  input wire logic                     RESET_N,
  // control and strobes
  input wire aesba_pkg::aesba_ctrl_t   CTRL,
  input wire logic                     INPUT_BYTE_WRITE,
  input wire logic                     OUTPUT_BYTE_READ,
  // results
  input wire aesba_pkg::aesba_status_t STATUS,
  input wire logic                     IRQ,
  input wire logic                     DMA_IN_REQ,
  input wire logic                     DMA_OUT_REQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  logic [10:0] since_wr_q;
  logic [10:0] since_wr_d;
  logic        any_err;
  assign any_err = STATUS.read_error_flag | STATUS.write_error_flag;
  // cycles since the latest input byte, saturating
  always_comb begin
    since_wr_d = since_wr_q;
    if (INPUT_BYTE_WRITE) since_wr_d = 11'h000;
    else if (since_wr_q != 11'h7ff) since_wr_d = since_wr_q + 11'h001;
  end
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) since_wr_q <= 11'h7ff;
    else since_wr_q <= since_wr_d;
  end
  sequence s_in_take; DMA_IN_REQ && INPUT_BYTE_WRITE; endsequence
  sequence s_out_take; DMA_OUT_REQ && OUTPUT_BYTE_READ; endsequence
  AST_DONE_CYCLES: assert property (
    $rose(STATUS.compute_done_flag) |-> since_wr_q == (CTRL.mode == 2'h1 ?
      11'h140 : CTRL.mode == 2'h3 ? 11'h4cc : 11'h37c))
    else $error("compute length off");
  AST_IRQ_MAP: assert property (
    $stable(CTRL.compute_done_irq_enable) && $stable(CTRL.error_irq_enable)
    |-> IRQ == (STATUS.compute_done_flag && CTRL.compute_done_irq_enable
      || any_err && CTRL.error_irq_enable))
    else $error("irq level wrong");
  AST_RD_ERR: assert property (
    OUTPUT_BYTE_READ && CTRL.enable && $past(CTRL.enable)
    && !CTRL.dma_request_enable && !STATUS.compute_done_flag
    |=> STATUS.read_error_flag) else $error("early read not flagged");
  AST_WR_ERR: assert property (
    INPUT_BYTE_WRITE && STATUS.compute_done_flag && !CTRL.dma_request_enable
    |=> STATUS.write_error_flag) else $error("late write not flagged");
  AST_ERR_CLR: assert property (
    CTRL.error_flags_clear && !INPUT_BYTE_WRITE && !OUTPUT_BYTE_READ
    |=> !any_err) else $error("error flags not cleared");
  AST_DONE_CLR: assert property (
    CTRL.compute_done_clear && STATUS.compute_done_flag
    && !CTRL.dma_request_enable |=> !STATUS.compute_done_flag)
    else $error("done flag not cleared");
  AST_NO_DMA: assert property (
    !$past(CTRL.dma_request_enable) |-> !DMA_IN_REQ && !DMA_OUT_REQ)
    else $error("request without dma");
  AST_IN_DROP: assert property (
    s_in_take |=> !DMA_IN_REQ) else $error("input request held");
  AST_OUT_DROP: assert property (
    s_out_take |=> !DMA_OUT_REQ) else $error("output request held");
  AST_DISABLE: assert property (
    !CTRL.enable |=> !DMA_IN_REQ && !DMA_OUT_REQ)
    else $error("request while disabled");
endmodule : aesba_core_props

bind aesba_core aesba_core_props u_props (
  .CORE_CLK, .RESET_N, .CTRL, .INPUT_BYTE_WRITE, .OUTPUT_BYTE_READ,
  .STATUS, .IRQ, .DMA_IN_REQ, .DMA_OUT_REQ);

// File: verification/aesba_dma_model.sv
// aesba_dma_model: byte-moving dma partner serving both request lines.
// assumes request levels that drop for a cycle after each strobe.
module aesba_dma_model (
  // clock, reset and control
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         active,
  input  wire logic         stall,
  input  wire logic [255:0] src,
  // device side
  input  wire logic         in_req,
  input  wire logic         out_req,
  output logic              wr,
  output logic [7:0]        wdata,
  output logic              rd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] idx;
  logic [1:0] cool;
  logic       go_wr;
  logic       go_rd;
  // serve one request when not cooling and not stalled
  assign go_wr = rst_n && active && cool == 2'h0 && !stall && in_req;
  assign go_rd = rst_n && active && cool == 2'h0 && !stall && !in_req
                 && out_req;
  always @(negedge clk) begin
    wr <= go_wr;
    rd <= go_rd;
    wdata <= go_wr ? src[255 - 8 * idx -: 8] : ~wdata;
    if (!rst_n || !active) begin
      idx <= 5'h00;
      cool <= 2'h0;
    end else if (cool != 2'h0) begin
      cool <= cool - 2'h1;
    end else if (go_wr || go_rd) begin
      if (go_wr) idx <= idx + 5'h01;
      cool <= 2'h2;
    end
  end
endmodule : aesba_dma_model

// File: verification/aesba_core_bench.sv
// aesba_core_bench: self-checking bench, cpu and dma byte traffic.
// assumes the props checker is bound and the dma model compiled before.
module aesba_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] EK = 128'h000102030405060708090a0b0c0d0e0f;
  localparam logic [127:0] PT = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] CT = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
  localparam logic [127:0] DK = 128'h13111d7fe3944a17f307a78b4d2b30c5;
  logic CORE_CLK = 1'b0;
  logic RESET_N = 1'b0;
  aesba_pkg::aesba_ctrl_t CTRL = 8'h00;
  logic c_wr = 1'b0, c_rd = 1'b0, c_legit = 1'b0, dma_sel = 1'b0;
  logic stall = 1'b0;
  logic [7:0] c_data = 8'h00;
  logic [255:0] dma_src = 256'h0;
  logic m_wr, m_rd, INPUT_BYTE_WRITE, OUTPUT_BYTE_READ;
  logic [7:0] m_data, INPUT_BYTE_REG, OUTPUT_BYTE_REG;
  aesba_pkg::aesba_status_t STATUS;
  logic IRQ, DMA_IN_REQ, DMA_OUT_REQ;
  int seed = 15;
  int num_errors = 0;
  int n_compared = 0;
  logic [7:0] exp_q[$];
  always #5 CORE_CLK = ~CORE_CLK;
  assign INPUT_BYTE_WRITE = dma_sel ? m_wr : c_wr;
  assign INPUT_BYTE_REG = dma_sel ? m_data : c_data;
  assign OUTPUT_BYTE_READ = dma_sel ? m_rd : c_rd;
  aesba_core dut (.CORE_CLK, .RESET_N, .CTRL, .INPUT_BYTE_WRITE,
    .INPUT_BYTE_REG, .OUTPUT_BYTE_READ, .OUTPUT_BYTE_REG, .STATUS, .IRQ,
    .DMA_IN_REQ, .DMA_OUT_REQ);
  aesba_dma_model dmac (.clk(CORE_CLK), .rst_n(RESET_N), .active(dma_sel),
    .stall(stall), .src(dma_src), .in_req(DMA_IN_REQ),
    .out_req(DMA_OUT_REQ), .wr(m_wr), .wdata(m_data), .rd(m_rd));
  always @(negedge CORE_CLK) stall <= dma_sel && ($random(seed) % 2 != 0);

  function automatic logic [255:0] mix(input logic [127:0] k, d);
    logic [255:0] r;
    for (int i = 0; i < 16; i++) begin
      r[255 - 16 * i -: 8] = k[127 - 8 * i -: 8];
      r[247 - 16 * i -: 8] = d[127 - 8 * i -: 8];
    end
    return r;
  endfunction : mix
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask : step
  task automatic gap;
    step(1 + $unsigned($random(seed)) % 3);
  endtask : gap
  task automatic put(input logic [7:0] b);
    c_wr = 1'b1; c_data = b; step(1);
    c_wr = 1'b0; c_data = ~b; gap();
  endtask : put
  task automatic get(input logic legit);
    c_rd = 1'b1; c_legit = legit; step(1);
    c_rd = 1'b0; gap();
  endtask : get
  task automatic setup(input logic [1:0] m);
    CTRL.enable = 1'b0; step(1);
    CTRL.mode = m; step(1);
    CTRL.enable = 1'b1; step(2);
  endtask : setup
  task automatic feed(input logic [255:0] s, input int n);
    for (int i = 0; i < n; i++) put(s[255 - 8 * i -: 8]);
  endtask : feed
  task automatic wait_done;
    for (int i = 0; i < 1500 && STATUS.compute_done_flag !== 1'b1; i++)
      step(1);
    if (STATUS.compute_done_flag !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask : wait_done
  task automatic fetch(input logic [127:0] r);
    for (int i = 0; i < 16; i++) begin
      exp_q.push_back(r[127 - 8 * i -: 8]);
      get(1'b1);
    end
  endtask : fetch
  task automatic clr(input logic d, input logic e);
    CTRL.compute_done_clear = d; CTRL.error_flags_clear = e; step(1);
    CTRL.compute_done_clear = 1'b0; CTRL.error_flags_clear = 1'b0; step(1);
  endtask : clr

  // output byte watcher, looks just before the sampling edge
  always @(negedge CORE_CLK) begin
    #4;
    if (OUTPUT_BYTE_READ && (dma_sel || c_legit)) begin
      if (exp_q.size() == 0) chk(8'h01, 8'h00);
      else chk(OUTPUT_BYTE_REG, exp_q.pop_front());
    end
  end

  initial begin
    repeat (5) @(posedge CORE_CLK);
    @(negedge CORE_CLK) RESET_N = 1'b1;
    CTRL.compute_done_irq_enable = 1'b1;
    setup(2'h0); feed(mix(EK, PT), 32); wait_done();
    chk({4'h0, IRQ, STATUS}, 8'h09);
    fetch(CT); clr(1'b1, 1'b0);
    chk({4'h0, IRQ, STATUS}, 8'h00);
    $display("test encrypt over");
    CTRL.error_irq_enable = 1'b1;
    setup(2'h1); get(1'b0);
    chk({4'h0, IRQ, STATUS}, 8'h0a);
    clr(1'b0, 1'b1);
    chk({4'h0, IRQ, STATUS}, 8'h00);
    feed({EK, 128'h0}, 16); wait_done(); put(8'h5a);
    chk({4'h0, IRQ, STATUS}, 8'h0d);
    fetch(DK); clr(1'b1, 1'b1);
    $display("test derive over");
    setup(2'h2); feed(mix(DK, CT), 32); get(1'b0);
    chk({4'h0, IRQ, STATUS}, 8'h0a);
    clr(1'b0, 1'b1); wait_done(); fetch(PT); clr(1'b1, 1'b0);
    $display("test decrypt over");
    setup(2'h3); feed(mix(EK, CT), 5);
    setup(2'h3); feed(mix(EK, CT), 32); wait_done();
    fetch(PT); clr(1'b1, 1'b0);
    $display("test restart over");
    CTRL.dma_request_enable = 1'b1;
    dma_src = mix(EK, CT);
    setup(2'h3);
    for (int i = 0; i < 32; i++) exp_q.push_back(PT[127 - 8 * (i % 16) -: 8]);
    dma_sel = 1'b1;
    for (int i = 0; i < 4000 && exp_q.size() != 0; i++) step(1);
    if (exp_q.size() != 0) begin
      num_errors++;
      conclude();
    end
    CTRL.enable = 1'b0; dma_sel = 1'b0; CTRL.dma_request_enable = 1'b0;
    step(2);
    chk({6'h00, DMA_IN_REQ, DMA_OUT_REQ}, 8'h00);
    clr(1'b1, 1'b1);
    chk({4'h0, IRQ, STATUS}, 8'h00);
    $display("test dma over");
    conclude();
  end
endmodule : aesba_core_bench
